// File: design/pts_defs.svh
// shared constants of the one-step frame time-stamper
`ifndef PTS_DEFS_SVH
`define PTS_DEFS_SVH

`define PTS_ETYPE 16'h88F7
`define PTS_POS_ETYPE_HI 16'h000C
`define PTS_POS_ETYPE_LO 16'h000D
`define PTS_POS_MSG 16'h000E
`define PTS_POS_CORR 16'h0016
`define PTS_POS_CORR_END 16'h001D
`define PTS_POS_RSV 16'h001E
`define PTS_POS_RSV_END 16'h0021
`define PTS_POS_SEQ_HI 16'h002C
`define PTS_POS_SEQ_LO 16'h002D
`define PTS_POS_OTS 16'h0030
`define PTS_POS_OTS_END 16'h0039
`define PTS_MSG_SYNC 4'h0
`define PTS_MSG_DREQ 4'h1
`define PTS_NS_PER_SEC 30'h3B9A_CA00
`define PTS_CLK_PERIOD_NS 30'h0000_000A
`define PTS_CRC_POLY 32'hEDB8_8320
`define PTS_CRC_INIT 32'hFFFF_FFFF
`define PTS_TICK_PERIOD 32'h0001_86A0

`endif

// File: design/pts_pkg.sv
// types and shared arithmetic of the one-step frame time-stamper
`include "pts_defs.svh"

package pts_pkg;

  typedef struct packed {
    logic v;
    logic last;
    logic [7:0] d;
  } pts_byte_s;

  typedef struct packed {
    logic [15:0] seq;
    logic [47:0] sec;
    logic [29:0] ns;
  } pts_stamp_s;

  // reflected ethernet crc, one byte
  function automatic logic [31:0] pts_crc_byte(input logic [31:0] c,
                                               input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h00_0000, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `PTS_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // {carry, ns} of a + b modulo one second
  function automatic logic [30:0] pts_ns_add(input logic [29:0] a,
                                             input logic [29:0] b);
    logic [30:0] s;
    logic [30:0] w;
    s = {1'b0, a} + {1'b0, b};
    w = s - {1'b0, `PTS_NS_PER_SEC};
    if (s >= {1'b0, `PTS_NS_PER_SEC}) begin
      return {1'b1, w[29:0]};
    end
    return s;
  endfunction

  // {borrow, ns} of a - b modulo one second
  function automatic logic [30:0] pts_ns_sub(input logic [29:0] a,
                                             input logic [29:0] b);
    if (a >= b) begin
      return {1'b0, a - b};
    end
    return {1'b1, a + (`PTS_NS_PER_SEC - b)};
  endfunction

  function automatic logic [7:0] pts_pick(input logic [79:0] v,
                                          input logic [3:0] idx);
    return v[{idx, 3'b000} +: 8];
  endfunction

endpackage

// File: design/pts_if.sv
// link between the system-side engine and the time-stamping phy
`timescale 1ns/100ps
`default_nettype none

interface pts_if;
  logic h2d_valid;
  logic [7:0] h2d_data;
  logic h2d_last;
  logic d2h_valid;
  logic [7:0] d2h_data;
  logic d2h_last;
  logic tick_load;
  logic cfg_sync_ots;
  logic cfg_dreq_tc;
  logic cfg_tick_save;

  modport dev (
    input h2d_valid, h2d_data, h2d_last, tick_load,
    input cfg_sync_ots, cfg_dreq_tc, cfg_tick_save,
    output d2h_valid, d2h_data, d2h_last
  );

  modport host (
    output h2d_valid, h2d_data, h2d_last, tick_load,
    output cfg_sync_ots, cfg_dreq_tc, cfg_tick_save,
    input d2h_valid, d2h_data, d2h_last
  );
endinterface

`default_nettype wire

// File: design/pts_dev.sv
// phy end: ingress/egress one-step time-stamping paths and local time
`timescale 1ns/100ps
`default_nettype none
`include "pts_defs.svh"

module pts_path #(
  parameter int DEPTH = 12,
  parameter bit EGRESS = 1'b0,
  parameter logic [29:0] LCORR_NS = 30'h0000_0000
) (
  input wire logic clk, // clock
  input wire logic rst, // sync reset
  input wire logic in_valid, // input byte valid
  input wire logic [7:0] in_data, // input byte
  input wire logic in_last, // last byte of frame
  input wire logic [47:0] now_sec, // local seconds
  input wire logic [29:0] now_ns, // local nanoseconds
  input wire logic cfg_sync_ots, // sync: 1 origin stamp, 0 correction
  input wire logic cfg_dreq_tc, // delay-req: 1 residence, 0 fifo
  output logic out_valid, // output byte valid
  output logic [7:0] out_data, // output byte
  output logic out_last, // last byte of frame
  output logic push, // one-cycle fifo write
  output pts_pkg::pts_stamp_s push_stamp // fifo write data
);
  // the stamp is taken at this path's own start of frame, so header
  // growth upstream (macsec) adds no error
  localparam logic [29:0] LAT =
    30'(DEPTH + 1) * `PTS_CLK_PERIOD_NS + LCORR_NS;

  logic [15:0] ipos;
  logic [15:0] opos;
  logic [7:0] etype_hi;
  logic is_ptp;
  logic is_sync;
  logic is_dreq;
  logic [47:0] st_sec;
  logic [29:0] st_ns;
  logic [63:0] corr;
  logic [31:0] rsv;
  logic [7:0] seq_hi;
  pts_pkg::pts_byte_s sr [DEPTH];
  pts_pkg::pts_byte_s tail;
  logic [31:0] crc_new;
  logic [31:0] crc_old;
  logic [30:0] ts_calc;
  logic [30:0] res;
  logic [47:0] ts_sec;
  logic [63:0] corr_new;
  logic [79:0] ots;
  logic wr_rsv;
  logic wr_ots;
  logic wr_corr;
  logic is_fcs;
  logic [1:0] fidx;
  logic [7:0] pbyte;
  logic [7:0] obyte;
  logic [31:0] fdiff;

  // input may already be cleartext: macsec sits ahead of this path
  always_ff @(posedge clk) begin
    if (rst) begin
      ipos <= 16'h0000;
    end else if (in_valid) begin
      ipos <= in_last ? 16'h0000 :
              (ipos == 16'hFFFF) ? ipos : ipos + 16'h0001;
    end
  end

  // frame recognition on the input side, ahead of the delay line
  always_ff @(posedge clk) begin
    if (rst) begin
      is_ptp <= 1'b0;
      is_sync <= 1'b0;
      is_dreq <= 1'b0;
      etype_hi <= 8'h00;
    end else if (in_valid) begin
      if (ipos == 16'h0000) begin
        is_ptp <= 1'b0;
        is_sync <= 1'b0;
        is_dreq <= 1'b0;
      end
      if (ipos == `PTS_POS_ETYPE_HI) begin
        etype_hi <= in_data;
      end
      if (ipos == `PTS_POS_ETYPE_LO) begin
        is_ptp <= ({etype_hi, in_data} == `PTS_ETYPE);
      end
      // any other message type, delay-response included, stays untouched
      if (ipos == `PTS_POS_MSG && is_ptp) begin
        is_sync <= (in_data[3:0] == `PTS_MSG_SYNC);
        is_dreq <= (in_data[3:0] == `PTS_MSG_DREQ);
      end
    end
  end

  // field capture
  always_ff @(posedge clk) begin
    if (rst) begin
      st_sec <= 48'h0000_0000_0000;
      st_ns <= 30'h0000_0000;
      corr <= 64'h0000_0000_0000_0000;
      rsv <= 32'h0000_0000;
      seq_hi <= 8'h00;
    end else if (in_valid) begin
      if (ipos == 16'h0000) begin
        st_sec <= now_sec;
        st_ns <= now_ns;
      end
      if (ipos >= `PTS_POS_CORR && ipos <= `PTS_POS_CORR_END) begin
        corr <= {corr[55:0], in_data};
      end
      if (ipos >= `PTS_POS_RSV && ipos <= `PTS_POS_RSV_END) begin
        rsv <= {rsv[23:0], in_data};
      end
      if (ipos == `PTS_POS_SEQ_HI) begin
        seq_hi <= in_data;
      end
    end
  end

  // ingress subtracts LCORR_NS, egress adds LAT: DEPTH+1 clock periods (delay line and output register) plus LCORR_NS
  assign ts_calc = EGRESS ? pts_pkg::pts_ns_add(st_ns, LAT)
                          : pts_pkg::pts_ns_sub(st_ns, LCORR_NS);
  assign ts_sec = EGRESS ? st_sec + 48'(ts_calc[30])
                         : st_sec - 48'(ts_calc[30]);
  // modulo-second difference stays positive across a second boundary
  assign res = pts_pkg::pts_ns_sub(ts_calc[29:0], rsv[29:0]);
  assign corr_new = corr + {18'h0_0000, res[29:0], 16'h0000};
  assign ots = {ts_sec, 2'b00, ts_calc[29:0]};

  assign wr_rsv = !EGRESS && (is_sync || is_dreq);
  assign wr_ots = EGRESS && is_sync && cfg_sync_ots;
  assign wr_corr = EGRESS && ((is_sync && !cfg_sync_ots) ||
                              (is_dreq && cfg_dreq_tc));

  // delay-req with residence mode off: actual tx time goes to the fifo
  always_ff @(posedge clk) begin
    if (rst) begin
      push <= 1'b0;
      push_stamp <= '0;
    end else begin
      push <= EGRESS && in_valid && ipos == `PTS_POS_SEQ_LO &&
              is_dreq && !cfg_dreq_tc;
      if (in_valid && ipos == `PTS_POS_SEQ_LO) begin
        push_stamp <= {seq_hi, in_data, ts_sec, ts_calc[29:0]};
      end
    end
  end

  // fixed delay line: lets late fields steer earlier bytes and the fcs
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        sr[i] <= '0;
      end
    end else begin
      sr[0] <= '{v: in_valid, last: in_valid && in_last, d: in_data};
      for (int i = 1; i < DEPTH; i++) begin
        sr[i] <= sr[i-1];
      end
    end
  end

  assign tail = sr[DEPTH-1];

  always_comb begin
    is_fcs = 1'b0;
    fidx = 2'd0;
    for (int j = 3; j >= 0; j--) begin
      if (sr[DEPTH-1-j].v && sr[DEPTH-1-j].last) begin
        is_fcs = tail.v;
        fidx = 2'(3 - j);
      end
    end
  end

  always_comb begin
    pbyte = tail.d;
    if (wr_rsv && opos >= `PTS_POS_RSV && opos <= `PTS_POS_RSV_END) begin
      pbyte = pts_pkg::pts_pick({48'h0, 2'b00, ts_calc[29:0]},
                                4'(`PTS_POS_RSV_END - opos));
    end
    if (wr_corr && opos >= `PTS_POS_CORR &&
        opos <= `PTS_POS_CORR_END) begin
      pbyte = pts_pkg::pts_pick({16'h0000, corr_new},
                                4'(`PTS_POS_CORR_END - opos));
    end
    if (wr_ots && opos >= `PTS_POS_OTS && opos <= `PTS_POS_OTS_END) begin
      pbyte = pts_pkg::pts_pick(ots, 4'(`PTS_POS_OTS_END - opos));
    end
  end

  // new fcs xor the old error pattern: a bad frame leaves still bad
  assign fdiff = crc_new ^ crc_old;
  assign obyte = is_fcs ? tail.d ^ fdiff[{fidx, 3'b000} +: 8] : pbyte;

  always_ff @(posedge clk) begin
    if (rst) begin
      opos <= 16'h0000;
      crc_new <= `PTS_CRC_INIT;
      crc_old <= `PTS_CRC_INIT;
    end else if (tail.v) begin
      opos <= tail.last ? 16'h0000 :
              (opos == 16'hFFFF) ? opos : opos + 16'h0001;
      if (tail.last) begin
        crc_new <= `PTS_CRC_INIT;
        crc_old <= `PTS_CRC_INIT;
      end else if (!is_fcs) begin
        crc_new <= pts_pkg::pts_crc_byte(crc_new, pbyte);
        crc_old <= pts_pkg::pts_crc_byte(crc_old, tail.d);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_data <= 8'h00;
      out_last <= 1'b0;
    end else begin
      out_valid <= tail.v;
      out_data <= tail.v ? obyte : 8'h00;
      out_last <= tail.last;
    end
  end
endmodule

module pts_dev #(
  parameter int DEPTH = 12,
  parameter int FIFO_DEPTH = 8,
  parameter logic [29:0] LCORR_NS = 30'h0000_0000
) (
  input wire logic clk, // common timetick clock
  input wire logic rst, // sync reset
  pts_if.dev ifc, // system side
  input wire logic line_rx_valid, // cleartext byte from line
  input wire logic [7:0] line_rx_data, // byte
  input wire logic line_rx_last, // last byte of frame
  output logic line_tx_valid, // byte toward line
  output logic [7:0] line_tx_data, // byte
  output logic line_tx_last, // last byte of frame
  input wire logic [47:0] load_sec, // seconds loaded on strobe
  input wire logic [29:0] load_ns, // nanoseconds loaded on strobe
  output logic [47:0] saved_sec, // seconds captured on strobe
  output logic [29:0] saved_ns, // nanoseconds captured on strobe
  output logic rd_valid, // fifo head valid
  input wire logic rd_ready, // fifo head taken
  output pts_pkg::pts_stamp_s rd_stamp, // fifo head
  output logic fifo_ovf // sticky, stamp dropped
);
  localparam int AW = $clog2(FIFO_DEPTH);

  logic [47:0] tod_sec;
  logic [29:0] tod_ns;
  logic [30:0] ns_step;
  logic ld_s1;
  logic ld_s2;
  logic ld_s3;
  logic ld_rise;
  logic push;
  pts_pkg::pts_stamp_s push_stamp;
  pts_pkg::pts_stamp_s mem [FIFO_DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW:0] count;
  logic take;
  logic full;

  // strobe arrives on a pin
  always_ff @(posedge clk) begin
    if (rst) begin
      ld_s1 <= 1'b0;
      ld_s2 <= 1'b0;
      ld_s3 <= 1'b0;
    end else begin
      ld_s1 <= ifc.tick_load;
      ld_s2 <= ld_s1;
      ld_s3 <= ld_s2;
    end
  end

  assign ld_rise = ld_s2 && !ld_s3;
  assign ns_step = pts_pkg::pts_ns_add(tod_ns, `PTS_CLK_PERIOD_NS);

  always_ff @(posedge clk) begin
    if (rst) begin
      tod_sec <= 48'h0000_0000_0000;
      tod_ns <= 30'h0000_0000;
    end else if (ld_rise && !ifc.cfg_tick_save) begin
      tod_sec <= load_sec;
      tod_ns <= load_ns;
    end else begin
      tod_sec <= tod_sec + 48'(ns_step[30]);
      tod_ns <= ns_step[29:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      saved_sec <= 48'h0000_0000_0000;
      saved_ns <= 30'h0000_0000;
    end else if (ld_rise && ifc.cfg_tick_save) begin
      // take the value this edge gives the counter, as a load would set it
      saved_sec <= tod_sec + 48'(ns_step[30]);
      saved_ns <= ns_step[29:0];
    end
  end

  // both paths run autonomously once the cfg levels are set
  pts_path #(.DEPTH(DEPTH), .EGRESS(1'b0), .LCORR_NS(LCORR_NS)) u_ing (
    .clk(clk),
    .rst(rst),
    .in_valid(line_rx_valid),
    .in_data(line_rx_data),
    .in_last(line_rx_last),
    .now_sec(tod_sec),
    .now_ns(tod_ns),
    .cfg_sync_ots(ifc.cfg_sync_ots),
    .cfg_dreq_tc(ifc.cfg_dreq_tc),
    .out_valid(ifc.d2h_valid),
    .out_data(ifc.d2h_data),
    .out_last(ifc.d2h_last),
    .push(),
    .push_stamp()
  );

  pts_path #(.DEPTH(DEPTH), .EGRESS(1'b1), .LCORR_NS(LCORR_NS)) u_egr (
    .clk(clk),
    .rst(rst),
    .in_valid(ifc.h2d_valid),
    .in_data(ifc.h2d_data),
    .in_last(ifc.h2d_last),
    .now_sec(tod_sec),
    .now_ns(tod_ns),
    .cfg_sync_ots(ifc.cfg_sync_ots),
    .cfg_dreq_tc(ifc.cfg_dreq_tc),
    .out_valid(line_tx_valid),
    .out_data(line_tx_data),
    .out_last(line_tx_last),
    .push(push),
    .push_stamp(push_stamp)
  );

  // tx stamp fifo; a full fifo drops the new stamp rather than stall
  assign full = (count == (AW+1)'(FIFO_DEPTH));
  assign take = (count != '0) && (!rd_valid || rd_ready);

  always_ff @(posedge clk) begin
    if (rst) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
      rd_valid <= 1'b0;
      rd_stamp <= '0;
      fifo_ovf <= 1'b0;
    end else begin
      if (push && !full) begin
        mem[wptr] <= push_stamp;
        wptr <= (wptr == AW'(FIFO_DEPTH - 1)) ? '0 : wptr + AW'(1);
      end
      if (push && full) begin
        fifo_ovf <= 1'b1;
      end
      if (take) begin
        rd_stamp <= mem[rptr];
        rd_valid <= 1'b1;
        rptr <= (rptr == AW'(FIFO_DEPTH - 1)) ? '0 : rptr + AW'(1);
      end else if (rd_ready) begin
        rd_valid <= 1'b0;
      end
      count <= count + (AW+1)'(push && !full) - (AW+1)'(take);
    end
  end
endmodule

`default_nettype wire

// File: design/pts_host.sv
// system end: ptp engine adapter, timetick load source and phy setup
`timescale 1ns/100ps
`default_nettype none
`include "pts_defs.svh"

module pts_host #(
  parameter int TICK_PERIOD = `PTS_TICK_PERIOD
) (
  input wire logic clk, // common timetick clock, also fed to the phy
  input wire logic rst, // sync reset
  pts_if.host ifc, // phy side
  input wire logic usr_tx_valid, // engine frame byte
  input wire logic [7:0] usr_tx_data, // byte
  input wire logic usr_tx_last, // last byte of frame
  output logic usr_rx_valid, // received byte
  output logic [7:0] usr_rx_data, // byte
  output logic usr_rx_last, // last byte of frame
  input wire logic [47:0] sw_sec, // engine software clock seconds
  input wire logic [29:0] sw_ns, // engine software clock ns
  input wire logic mod_alg, // rewrite delay-req for residence mode
  input wire logic cfg_sync_ots, // setup value toward the phy
  input wire logic cfg_dreq_tc, // setup value toward the phy
  input wire logic cfg_tick_save // setup value toward the phy
);
  logic [31:0] tick_cnt;
  logic [15:0] ipos;
  logic [15:0] opos;
  logic [7:0] etype_hi;
  logic is_ptp;
  logic is_dreq;
  logic [47:0] t3_sec;
  logic [29:0] t3_ns;
  pts_pkg::pts_byte_s sr [4];
  pts_pkg::pts_byte_s tail;
  logic [31:0] crc_new;
  logic [31:0] crc_old;
  logic [31:0] fdiff;
  logic is_fcs;
  logic [1:0] fidx;
  logic [7:0] pbyte;
  logic wr;

  // identical setup per phy keeps redundant blades interchangeable
  always_ff @(posedge clk) begin
    if (rst) begin
      ifc.cfg_sync_ots <= 1'b0;
      ifc.cfg_dreq_tc <= 1'b0;
      ifc.cfg_tick_save <= 1'b0;
    end else begin
      ifc.cfg_sync_ots <= cfg_sync_ots;
      ifc.cfg_dreq_tc <= cfg_dreq_tc;
      ifc.cfg_tick_save <= cfg_tick_save;
    end
  end

  // global load pulse, one cycle every TICK_PERIOD cycles of clk
  always_ff @(posedge clk) begin
    if (rst) begin
      tick_cnt <= 32'h0000_0000;
      ifc.tick_load <= 1'b0;
    end else begin
      ifc.tick_load <= (tick_cnt == 32'(TICK_PERIOD - 1));
      tick_cnt <= (tick_cnt == 32'(TICK_PERIOD - 1)) ? 32'h0000_0000
                                                    : tick_cnt + 32'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ipos <= 16'h0000;
      etype_hi <= 8'h00;
      is_ptp <= 1'b0;
      is_dreq <= 1'b0;
      t3_sec <= 48'h0000_0000_0000;
      t3_ns <= 30'h0000_0000;
    end else if (usr_tx_valid) begin
      ipos <= usr_tx_last ? 16'h0000 :
              (ipos == 16'hFFFF) ? ipos : ipos + 16'h0001;
      if (ipos == 16'h0000) begin
        is_ptp <= 1'b0;
        is_dreq <= 1'b0;
        // taken before the frame leaves: always under a second early
        t3_sec <= sw_sec;
        t3_ns <= sw_ns;
      end
      if (ipos == `PTS_POS_ETYPE_HI) begin
        etype_hi <= usr_tx_data;
      end
      if (ipos == `PTS_POS_ETYPE_LO) begin
        is_ptp <= ({etype_hi, usr_tx_data} == `PTS_ETYPE);
      end
      if (ipos == `PTS_POS_MSG && is_ptp) begin
        is_dreq <= (usr_tx_data[3:0] == `PTS_MSG_DREQ);
      end
    end
  end

  // four-byte delay so the fcs can be replaced after the rewrite
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) begin
        sr[i] <= '0;
      end
    end else begin
      sr[0] <= '{v: usr_tx_valid, last: usr_tx_valid && usr_tx_last,
                 d: usr_tx_data};
      for (int i = 1; i < 4; i++) begin
        sr[i] <= sr[i-1];
      end
    end
  end

  assign tail = sr[3];
  assign wr = mod_alg && is_dreq;

  always_comb begin
    is_fcs = 1'b0;
    fidx = 2'd0;
    for (int j = 3; j >= 0; j--) begin
      if (sr[3-j].v && sr[3-j].last) begin
        is_fcs = tail.v;
        fidx = 2'(3 - j);
      end
    end
  end

  always_comb begin
    pbyte = tail.d;
    if (wr && opos >= `PTS_POS_CORR && opos <= `PTS_POS_CORR_END) begin
      pbyte = 8'h00;
    end
    if (wr && opos >= `PTS_POS_RSV && opos <= `PTS_POS_RSV_END) begin
      pbyte = pts_pkg::pts_pick({48'h0, 2'b00, t3_ns},
                                4'(`PTS_POS_RSV_END - opos));
    end
    if (wr && opos >= `PTS_POS_OTS && opos <= `PTS_POS_OTS_END) begin
      pbyte = pts_pkg::pts_pick({t3_sec, 2'b00, t3_ns},
                                4'(`PTS_POS_OTS_END - opos));
    end
  end

  assign fdiff = crc_new ^ crc_old;

  always_ff @(posedge clk) begin
    if (rst) begin
      opos <= 16'h0000;
      crc_new <= `PTS_CRC_INIT;
      crc_old <= `PTS_CRC_INIT;
      ifc.h2d_valid <= 1'b0;
      ifc.h2d_data <= 8'h00;
      ifc.h2d_last <= 1'b0;
    end else begin
      ifc.h2d_valid <= tail.v;
      ifc.h2d_last <= tail.last;
      ifc.h2d_data <= !tail.v ? 8'h00 :
                      is_fcs ? tail.d ^ fdiff[{fidx, 3'b000} +: 8] : pbyte;
      if (tail.v) begin
        opos <= tail.last ? 16'h0000 :
                (opos == 16'hFFFF) ? opos : opos + 16'h0001;
        if (tail.last) begin
          crc_new <= `PTS_CRC_INIT;
          crc_old <= `PTS_CRC_INIT;
        end else if (!is_fcs) begin
          crc_new <= pts_pkg::pts_crc_byte(crc_new, pbyte);
          crc_old <= pts_pkg::pts_crc_byte(crc_old, tail.d);
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      usr_rx_valid <= 1'b0;
      usr_rx_data <= 8'h00;
      usr_rx_last <= 1'b0;
    end else begin
      usr_rx_valid <= ifc.d2h_valid;
      usr_rx_data <= ifc.d2h_data;
      usr_rx_last <= ifc.d2h_last;
    end
  end
endmodule

`default_nettype wire

// File: verif/pts_props.sv
// assertions on the link between the engine end and the phy end
`timescale 1ns/100ps
`default_nettype none

module pts_props #(
  parameter int TICK_PERIOD = 40
) (
  input wire logic clk, // clock
  input wire logic rst, // sync reset
  input wire logic h2d_valid, // byte toward phy
  input wire logic h2d_last, // its last byte
  input wire logic d2h_valid, // byte toward engine
  input wire logic d2h_last, // its last byte
  input wire logic tick_load // load strobe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [31:0] gap;
  logic seen;
  logic [15:0] hcnt;
  logic [15:0] dcnt;
  always_ff @(posedge clk) begin
    gap <= (rst || tick_load) ? 32'h0000_0000 : gap + 32'h0000_0001;
  end
  // first strobe after reset has no previous one to measure from
  always_ff @(posedge clk) begin
    seen <= !rst && (seen || tick_load);
  end
  always_ff @(posedge clk) begin
    if (rst || (h2d_valid && h2d_last)) hcnt <= 16'h0000;
    else if (h2d_valid) hcnt <= hcnt + 16'h0001;
  end
  always_ff @(posedge clk) begin
    if (rst || (d2h_valid && d2h_last)) dcnt <= 16'h0000;
    else if (d2h_valid) dcnt <= dcnt + 16'h0001;
  end
  sequence s_tick;
    tick_load ##1 !tick_load;
  endsequence
  sequence s_h_end;
    h2d_last ##1 !h2d_valid [*8];
  endsequence
  sequence s_d_end;
    d2h_last ##1 !d2h_valid [*8];
  endsequence
  a_tick_pulse: assert property (tick_load |-> s_tick)
    else $error("load strobe longer than one cycle");
  a_tick_period: assert property (
    tick_load && seen |-> gap == TICK_PERIOD - 1)
    else $error("load strobe spacing wrong");
  a_tick_bound: assert property (gap <= TICK_PERIOD)
    else $error("load strobe missing");
  a_h2d_frame: assert property (
    h2d_last |-> h2d_valid && hcnt >= 16'h003F)
    else $error("short frame toward phy");
  a_h2d_gap: assert property (h2d_last |-> s_h_end)
    else $error("no idle gap toward phy");
  a_d2h_frame: assert property (
    d2h_last |-> d2h_valid && dcnt >= 16'h003F)
    else $error("short frame toward engine");
  a_d2h_gap: assert property (d2h_last |-> s_d_end)
    else $error("no idle gap toward engine");
  a_d2h_sof: assert property ($rose(d2h_valid) |-> dcnt == 16'h0000)
    else $error("frame toward engine split");
endmodule

`default_nettype wire

// File: verif/test_ptp_one_step_frame_timestamper.sv
// self-checking bench joining the engine end and the phy end
`timescale 1ns/100ps
`default_nettype none

module test_ptp_one_step_frame_timestamper;
  localparam int TP = 40;
  logic clk = 1'b0;
  logic rst, ut_v, ut_l, lr_v, lr_l, ur_v, ur_l, lt_v, lt_l;
  logic [7:0] ut_d, lr_d, ur_d, lt_d;
  logic [47:0] load_sec, saved_sec, sw_sec;
  logic [29:0] load_ns, saved_ns, sw_ns;
  logic rd_valid, rd_ready, ovf, mod_alg, ots, tc, tsave;
  pts_pkg::pts_stamp_s rd_stamp;
  logic [7:0] fr[$], rq[$], tq[$], oq[$];
  int bad_count, cmp_count, sof;
  int cyc = 0;
  always #5 clk = ~clk;
  pts_if pts_if_i ();
  pts_dev pts_dev_i (.clk(clk), .rst(rst), .ifc(pts_if_i.dev),
    .line_rx_valid(lr_v), .line_rx_data(lr_d), .line_rx_last(lr_l),
    .line_tx_valid(lt_v), .line_tx_data(lt_d), .line_tx_last(lt_l),
    .load_sec(load_sec), .load_ns(load_ns), .saved_sec(saved_sec),
    .saved_ns(saved_ns), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .rd_stamp(rd_stamp), .fifo_ovf(ovf));
  pts_host #(.TICK_PERIOD(TP)) pts_host_i (.clk(clk), .rst(rst),
    .ifc(pts_if_i.host), .usr_tx_valid(ut_v), .usr_tx_data(ut_d),
    .usr_tx_last(ut_l), .usr_rx_valid(ur_v), .usr_rx_data(ur_d),
    .usr_rx_last(ur_l), .sw_sec(sw_sec), .sw_ns(sw_ns), .mod_alg(mod_alg),
    .cfg_sync_ots(ots), .cfg_dreq_tc(tc), .cfg_tick_save(tsave));
  pts_props #(.TICK_PERIOD(TP)) pts_props_i (.clk(clk), .rst(rst),
    .h2d_valid(pts_if_i.h2d_valid), .h2d_last(pts_if_i.h2d_last),
    .d2h_valid(pts_if_i.d2h_valid), .d2h_last(pts_if_i.d2h_last),
    .tick_load(pts_if_i.tick_load));
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (ur_v) rq.push_back(ur_d);
    if (lt_v) tq.push_back(lt_d);
  end
  task automatic chk(input string nm, input logic [63:0] e,
                     input logic [63:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  function automatic logic [31:0] crc(input logic [7:0] a[$], input int n);
    logic [31:0] c;
    c = 32'hFFFF_FFFF;
    for (int i = 0; i < n; i++) begin
      c = c ^ {24'h00_0000, a[i]};
      for (int k = 0; k < 8; k++)
        c = c[0] ? (c >> 1) ^ 32'hEDB8_8320 : c >> 1;
    end
    return c;
  endfunction
  function automatic logic [63:0] corr();
    return {oq[22], oq[23], oq[24], oq[25], oq[26], oq[27], oq[28], oq[29]};
  endfunction
  function automatic logic [31:0] rsv();
    return {oq[30], oq[31], oq[32], oq[33]};
  endfunction
  task automatic mk(input logic [3:0] msg, input logic [15:0] seq);
    logic [31:0] c;
    fr = {};
    for (int i = 0; i < 60; i++) fr.push_back(8'h00);
    fr[12] = 8'h88;
    fr[13] = 8'hF7;
    fr[14] = {4'h0, msg};
    fr[44] = seq[15:8];
    fr[45] = seq[7:0];
    c = ~crc(fr, 60);
    for (int i = 0; i < 4; i++) fr.push_back(c[8*i +: 8]);
  endtask
  // eg=1 engine to line, eg=0 line to engine; result lands in oq
  task automatic xfer(input bit eg);
    int n;
    rq = {};
    tq = {};
    for (int i = 0; i < 64; i++) begin
      @(posedge clk);
      #1;
      if (i == 0) sof = cyc;
      if (eg) {ut_v, ut_l, ut_d} = {1'b1, i == 63, fr[i]};
      else {lr_v, lr_l, lr_d} = {1'b1, i == 63, fr[i]};
    end
    @(posedge clk);
    #1;
    {ut_v, ut_l, lr_v, lr_l} = 4'h0;
    for (n = 0; n < 100 && (eg ? tq.size() : rq.size()) < 64; n++)
      @(posedge clk);
    repeat (20) @(posedge clk);
    // leave the edge so later drives and reads stay off it
    #1;
    if (eg) oq = tq;
    else oq = rq;
    chk("frame length", 64'(64), 64'(oq.size()));
    if (n == 100) finish_test();
    chk("fcs residue", 32'hDEBB_20E3, crc(oq, 64));
  endtask
  task automatic t_load;
    logic [29:0] s;
    int n;
    load_sec = 48'h0000_0000_0005;
    load_ns = 30'h0000_03E8;
    repeat (3 * TP) @(posedge clk);
    #1 tsave = 1'b1;
    s = saved_ns;
    for (n = 0; n < 3 * TP && saved_ns === s; n++) @(posedge clk);
    #1 chk("saved ns", 1000 + TP * 10, saved_ns);
    chk("saved sec", 48'h0000_0000_0005, saved_sec);
  endtask
  task automatic t_rx;
    logic [31:0] a;
    int s;
    mk(4'h0, 16'h0001);
    xfer(0);
    a = rsv();
    s = sof;
    mk(4'h1, 16'h0002);
    xfer(0);
    chk("rx stamp step", 64'((sof - s) * 10),
        rsv() - a);
  endtask
  task automatic t_pass;
    mk(4'h9, 16'h0003);
    for (int e = 0; e < 2; e++) begin
      xfer(e[0]);
      for (int i = 0; i < 64; i++) chk("pass byte", fr[i], oq[i]);
    end
  endtask
  task automatic t_ots;
    ots = 1'b1;
    mk(4'h0, 16'h0004);
    xfer(1);
    chk("origin sec", 48'h0000_0000_0005,
        {oq[48], oq[49], oq[50], oq[51], oq[52], oq[53]});
  endtask
  task automatic t_fifo;
    mk(4'h1, 16'h1234);
    xfer(1);
    chk("fifo valid", 1'b1, rd_valid);
    chk("fifo seq", 16'h1234, rd_stamp.seq);
    chk("fifo sec", 48'h0000_0000_0005, rd_stamp.sec);
    rd_ready = 1'b1;
    @(posedge clk);
    #1 rd_ready = 1'b0;
    @(posedge clk);
    #1 chk("fifo empty", 2'h0, {rd_valid, ovf});
  endtask
  // second frame's software t3 sits just under a second boundary
  task automatic t_tc;
    logic [63:0] a;
    int s;
    {mod_alg, tc} = 2'h3;
    mk(4'h1, 16'h0005);
    xfer(1);
    a = corr() >> 16;
    s = sof;
    sw_ns = 30'h3B9A_C618;
    xfer(1);
    chk("residence step", 64'((sof - s) * 10 + 1000),
        (corr() >> 16) - a);
  endtask
  initial begin
    {ut_v, ut_l, lr_v, lr_l, rd_ready, mod_alg, ots, tc, tsave} = 9'h000;
    {ut_d, lr_d} = 16'h0000;
    {load_sec, sw_sec} = 96'h0;
    {load_ns, sw_ns} = 60'h0;
    rst = 1'b1;
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    t_load();
    t_rx();
    t_pass();
    t_ots();
    t_fifo();
    t_tc();
    finish_test();
  end
endmodule

`default_nettype wire
